// file: hw/fpg_guard.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Both key codes in order unlock flash
// - Key spacing free; order and values matter
// - Wrong key or early access disables until reset
// - One unlock permits exactly one operation
// - Key read returns two-bit lock state
// - Write enable alone programs one byte
// - Both enables erase the addressed page
// - External reads always go to data RAM
// - Control register resets zero, upper bits zero
// - Complemented lock byte counts protected pages
// - Any zero lock bit protects lock page
// - Debug port denied on protected pages, except device erase
// - Unprotected code denied on protected pages
// - Protected code reaches all but reserved region
// - Protected code cannot erase reserved, lock page
// - Only debug device erase clears protection
// - Denied firmware access forces flash-error reset
// - Byte program lasts forty to seventy microseconds
// - One-shot bit resets one; clear widens sensing
// - Page erase sets bytes to ones
// - Programming only clears bits
// - Core stalls during write or erase
// - Lock returns to locked after each operation
module fpg_guard
  import fpg_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_xwr,
  input wire fpg_xwr_t i_xwr_req,
  input wire logic i_xrd,
  input wire logic [15:0] i_xrd_addr,
  input wire logic [15:0] i_pc,
  input wire logic i_code_rd,
  input wire logic [15:0] i_code_addr,
  output logic [7:0] o_code_data,
  input wire logic i_dbg_req,
  input wire fpg_dbg_t i_dbg,
  output logic o_dbg_ack,
  output logic o_dbg_denied,
  output logic [7:0] o_dbg_rdata,
  output logic o_data_ram_wr,
  output fpg_xwr_t o_data_ram_wreq,
  output logic o_data_ram_rd,
  output logic [15:0] o_data_ram_raddr,
  output logic o_core_stall,
  output logic o_flash_err_rst,
  output logic o_sense_full_cycle
);
  logic [7:0] flash_mem [FLASH_BYTES];
  logic write_en_reg;
  logic erase_en_reg;
  logic oneshot_reg;
  fpg_key_t key_reg;
  fpg_state_t state_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic [ADDR_W-1:0] op_addr_reg;
  logic [7:0] op_data_reg;
  logic [7:0] lock_byte;
  logic [7:0] lock_count;
  logic lock_byte_set;
  logic flash_wr_try;
  logic fw_op_deny;
  logic fw_rd_deny;
  logic dbg_deny;
  logic op_start;
  logic op_done;
  logic [ADDR_W-1:0] xw_addr;
  logic [PAGE_W-1:0] xw_page;
  logic [PAGE_W-1:0] pc_page;
  logic pc_locked;
  logic key_wr;

  function automatic logic page_locked(input logic [PAGE_W-1:0] pg, input logic [7:0] cnt,
                                       input logic lock_pg_on);
    logic hit;
    hit = ({{(8-PAGE_W){1'b0}}, pg} < cnt);
    if (lock_pg_on && (pg == LOCK_BYTE_ADDR[ADDR_W-1:PAGE_OFS_W])) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  assign lock_byte = flash_mem[LOCK_BYTE_ADDR];
  assign lock_count = ~lock_byte;
  assign lock_byte_set = (lock_byte != ERASED_BYTE);

  assign xw_addr = i_xwr_req.addr[ADDR_W-1:0];
  assign xw_page = xw_addr[ADDR_W-1:PAGE_OFS_W];
  assign pc_page = i_pc[ADDR_W-1:PAGE_OFS_W];
  assign pc_locked = page_locked(pc_page, lock_count, lock_byte_set);
  assign key_wr = i_sfr_wr && (i_sfr_addr == SFR_UNLOCK_KEY);
  assign flash_wr_try = i_xwr && write_en_reg && (state_reg == FPG_ST_IDLE);

  always_comb begin
    fw_op_deny = 1'b0;
    if (!pc_locked) begin
      fw_op_deny = page_locked(xw_page, lock_count, lock_byte_set);
    end else begin
      fw_op_deny = (xw_addr >= RESERVED_BASE);
      if (erase_en_reg && (xw_page == LOCK_BYTE_ADDR[ADDR_W-1:PAGE_OFS_W])) begin
        fw_op_deny = 1'b1;
      end
    end
  end

  always_comb begin
    fw_rd_deny = 1'b0;
    if (i_code_rd) begin
      if (!pc_locked) begin
        fw_rd_deny = page_locked(i_code_addr[ADDR_W-1:PAGE_OFS_W], lock_count, lock_byte_set);
      end else begin
        fw_rd_deny = (i_code_addr[ADDR_W-1:0] >= RESERVED_BASE);
      end
    end
  end

  assign dbg_deny = (i_dbg.cmd != FPG_DBG_DEVICE_ERASE) &&
                    page_locked(i_dbg.addr[ADDR_W-1:PAGE_OFS_W], lock_count, lock_byte_set);

  assign op_start = flash_wr_try && (key_reg == FPG_KEY_OPEN) && !fw_op_deny;
  assign op_done = (state_reg != FPG_ST_IDLE) && (timer_reg == '0);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      write_en_reg <= STORE_CTRL_RESET[STORE_WRITE_EN_BIT];
      erase_en_reg <= STORE_CTRL_RESET[STORE_ERASE_EN_BIT];
    end else if (i_sfr_wr && (i_sfr_addr == SFR_STORE_CTRL)) begin
      write_en_reg <= i_sfr_wdata[STORE_WRITE_EN_BIT];
      erase_en_reg <= i_sfr_wdata[STORE_ERASE_EN_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      oneshot_reg <= FLASH_SCALE_RESET[ONESHOT_EN_BIT];
      o_sense_full_cycle <= ~FLASH_SCALE_RESET[ONESHOT_EN_BIT];
    end else if (i_sfr_wr && (i_sfr_addr == SFR_FLASH_SCALE)) begin
      oneshot_reg <= i_sfr_wdata[ONESHOT_EN_BIT];
      o_sense_full_cycle <= ~i_sfr_wdata[ONESHOT_EN_BIT];
    end
  end

  // Dead state only leaves on reset, so it is checked first
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      key_reg <= FPG_KEY_LOCKED;
    end else if (key_reg == FPG_KEY_DEAD) begin
      key_reg <= FPG_KEY_DEAD;
    end else if (key_wr) begin
      case (key_reg)
        FPG_KEY_LOCKED: begin
          key_reg <= (i_sfr_wdata == KEY_FIRST) ? FPG_KEY_FIRST : FPG_KEY_DEAD;
        end
        FPG_KEY_FIRST: begin
          key_reg <= (i_sfr_wdata == KEY_SECOND) ? FPG_KEY_OPEN : FPG_KEY_DEAD;
        end
        default: begin
          key_reg <= FPG_KEY_DEAD;
        end
      endcase
    end else if (flash_wr_try && (key_reg != FPG_KEY_OPEN)) begin
      key_reg <= FPG_KEY_DEAD;
    end else if (op_done) begin
      key_reg <= FPG_KEY_LOCKED;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= FPG_ST_IDLE;
      timer_reg <= '0;
      op_addr_reg <= '0;
      op_data_reg <= '0;
      o_core_stall <= 1'b0;
    end else if (op_start) begin
      op_addr_reg <= xw_addr;
      op_data_reg <= i_xwr_req.data;
      o_core_stall <= 1'b1;
      if (erase_en_reg) begin
        state_reg <= FPG_ST_ERASE;
        timer_reg <= TIMER_W'(ERASE_CYCLES - 1);
      end else begin
        state_reg <= FPG_ST_PROG;
        timer_reg <= TIMER_W'(PROG_CYCLES - 1);
      end
    end else if (op_done) begin
      state_reg <= FPG_ST_IDLE;
      o_core_stall <= 1'b0;
    end else if (state_reg != FPG_ST_IDLE) begin
      timer_reg <= timer_reg - 1'b1;
    end
  end

  // Array is not reset: it models non-volatile storage
  always_ff @(posedge i_clk) begin
    if (op_done && (state_reg == FPG_ST_PROG)) begin
      flash_mem[op_addr_reg] <= flash_mem[op_addr_reg] & op_data_reg;
    end else if (op_done && (state_reg == FPG_ST_ERASE)) begin
      for (int i = 0; i < (1 << PAGE_OFS_W); i++) begin
        flash_mem[{op_addr_reg[ADDR_W-1:PAGE_OFS_W], PAGE_OFS_W'(i)}] <= ERASED_BYTE;
      end
    end else if (!i_rst && i_dbg_req && !dbg_deny) begin
      case (i_dbg.cmd)
        FPG_DBG_WRITE: begin
          flash_mem[i_dbg.addr] <= flash_mem[i_dbg.addr] & i_dbg.data;
        end
        FPG_DBG_ERASE: begin
          for (int i = 0; i < (1 << PAGE_OFS_W); i++) begin
            flash_mem[{i_dbg.addr[ADDR_W-1:PAGE_OFS_W], PAGE_OFS_W'(i)}] <= ERASED_BYTE;
          end
        end
        FPG_DBG_DEVICE_ERASE: begin
          for (int i = 0; i < FLASH_BYTES; i++) begin
            flash_mem[i] <= ERASED_BYTE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_flash_err_rst <= 1'b0;
    end else begin
      o_flash_err_rst <= (flash_wr_try && (key_reg == FPG_KEY_OPEN) && fw_op_deny) ||
                         fw_rd_deny;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_code_data <= '0;
    end else if (i_code_rd) begin
      o_code_data <= fw_rd_deny ? 8'h00 : flash_mem[i_code_addr[ADDR_W-1:0]];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_dbg_ack <= 1'b0;
      o_dbg_denied <= 1'b0;
      o_dbg_rdata <= '0;
    end else begin
      o_dbg_ack <= i_dbg_req;
      o_dbg_denied <= i_dbg_req && dbg_deny;
      if (i_dbg_req && (i_dbg.cmd == FPG_DBG_READ)) begin
        o_dbg_rdata <= dbg_deny ? 8'h00 : flash_mem[i_dbg.addr];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_data_ram_wr <= 1'b0;
      o_data_ram_wreq <= '0;
      o_data_ram_rd <= 1'b0;
      o_data_ram_raddr <= '0;
    end else begin
      o_data_ram_wr <= i_xwr && !write_en_reg;
      if (i_xwr && !write_en_reg) begin
        o_data_ram_wreq <= i_xwr_req;
      end
      o_data_ram_rd <= i_xrd;
      if (i_xrd) begin
        o_data_ram_raddr <= i_xrd_addr;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sfr_rdata <= '0;
    end else if (i_sfr_rd) begin
      case (i_sfr_addr)
        SFR_STORE_CTRL: o_sfr_rdata <= {6'h00, erase_en_reg, write_en_reg};
        SFR_FLASH_SCALE: o_sfr_rdata <= {oneshot_reg, 7'h00};
        SFR_UNLOCK_KEY: o_sfr_rdata <= {6'h00, key_reg};
        default: o_sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Helper: length of the last stall
  logic [TIMER_W-1:0] stall_len;
  logic last_prog;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stall_len <= '0;
      last_prog <= 1'b0;
    end else if (op_start) begin
      stall_len <= '0;
      last_prog <= !erase_en_reg;
    end else if (o_core_stall) begin
      stall_len <= stall_len + 1'b1;
    end
  end

  key_first_a: assert property (@(posedge i_clk) disable iff (i_rst)
    key_wr && (key_reg == FPG_KEY_LOCKED) && (i_sfr_wdata == KEY_FIRST)
    |=> (key_reg == FPG_KEY_FIRST))
    else $error("first key not accepted");
  key_open_a: assert property (@(posedge i_clk) disable iff (i_rst)
    key_wr && (key_reg == FPG_KEY_FIRST) && (i_sfr_wdata == KEY_SECOND)
    |=> (key_reg == FPG_KEY_OPEN))
    else $error("second key not accepted");
  dead_sticky_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (key_reg == FPG_KEY_DEAD) |=> (key_reg == FPG_KEY_DEAD) [*4])
    else $error("disabled lock state left without reset");
  relock_done_a: assert property (@(posedge i_clk) disable iff (i_rst)
    op_done && (key_reg == FPG_KEY_OPEN) && !key_wr |=> (key_reg == FPG_KEY_LOCKED))
    else $error("lock not restored after operation");
  prog_length_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_core_stall) && last_prog |-> (stall_len == TIMER_W'(PROG_CYCLES)))
    else $error("program stall length wrong");
  stall_start_a: assert property (@(posedge i_clk) disable iff (i_rst)
    op_start |=> o_core_stall && (state_reg != FPG_ST_IDLE))
    else $error("core not stalled at operation start");
  deny_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
    fw_rd_deny |=> o_flash_err_rst)
    else $error("denied read gave no flash error reset");
  ram_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_xrd |=> o_data_ram_rd && (o_data_ram_raddr == $past(i_xrd_addr)))
    else $error("external read not sent to data RAM");
  key_readback_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_sfr_rd && (i_sfr_addr == SFR_UNLOCK_KEY) |=> (o_sfr_rdata[1:0] == $past(key_reg)))
    else $error("key register readback wrong");
  sense_wide_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_sfr_wr && (i_sfr_addr == SFR_FLASH_SCALE) |=> (o_sense_full_cycle == !$past(i_sfr_wdata[7])))
    else $error("one-shot control not applied");
endmodule

// file: hw/fpg_pkg.sv
package fpg_pkg;
  localparam int FLASH_BYTES = 16384;
  localparam int ADDR_W = 14;
  localparam int PAGE_OFS_W = 9;
  localparam int PAGE_W = ADDR_W - PAGE_OFS_W;
  localparam logic [7:0] SFR_STORE_CTRL = 8'h8f;
  localparam logic [7:0] SFR_FLASH_SCALE = 8'hb6;
  localparam logic [7:0] SFR_UNLOCK_KEY = 8'hb7;
  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;
  localparam logic [7:0] STORE_CTRL_RESET = 8'h00;
  localparam logic [7:0] FLASH_SCALE_RESET = 8'h80;
  localparam int STORE_WRITE_EN_BIT = 0;
  localparam int STORE_ERASE_EN_BIT = 1;
  localparam int ONESHOT_EN_BIT = 7;
  localparam logic [ADDR_W-1:0] LOCK_BYTE_ADDR = 14'h3dff;
  localparam logic [ADDR_W-1:0] RESERVED_BASE = 14'h3e00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_MIN_NS = 40000;
  localparam int PROG_MAX_NS = 70000;
  localparam int ERASE_MIN_NS = 10000000;
  localparam int PROG_CYCLES = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES_DEF = (ERASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 17;

  typedef enum logic [1:0] {
    FPG_KEY_LOCKED = 2'b00,
    FPG_KEY_FIRST = 2'b01,
    FPG_KEY_OPEN = 2'b10,
    FPG_KEY_DEAD = 2'b11
  } fpg_key_t;

  typedef enum logic [1:0] {
    FPG_ST_IDLE = 2'b00,
    FPG_ST_PROG = 2'b01,
    FPG_ST_ERASE = 2'b10
  } fpg_state_t;

  typedef enum logic [1:0] {
    FPG_DBG_READ = 2'b00,
    FPG_DBG_WRITE = 2'b01,
    FPG_DBG_ERASE = 2'b10,
    FPG_DBG_DEVICE_ERASE = 2'b11
  } fpg_dbg_cmd_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } fpg_xwr_t;

  typedef struct packed {
    fpg_dbg_cmd_t cmd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } fpg_dbg_t;
endpackage

// file: sim/fpg_core_model.sv
`timescale 1ns/1ps
module fpg_core_model
  import fpg_pkg::*;
(
  input wire logic i_clk,
  input wire logic [7:0] i_sfr_rdata,
  input wire logic i_core_stall,
  output logic o_sfr_wr,
  output logic o_sfr_rd,
  output logic [7:0] o_sfr_addr,
  output logic [7:0] o_sfr_wdata,
  output logic o_xwr,
  output fpg_xwr_t o_xwr_req,
  output logic o_xrd,
  output logic [15:0] o_xrd_addr
);
  initial begin
    o_sfr_wr = 1'b0;
    o_sfr_rd = 1'b0;
    o_sfr_addr = 8'h00;
    o_sfr_wdata = 8'h00;
    o_xwr = 1'b0;
    o_xwr_req = '0;
    o_xrd = 1'b0;
    o_xrd_addr = 16'h0000;
  end

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_sfr_wr <= 1'b1;
    o_sfr_addr <= a;
    o_sfr_wdata <= d;
    @(posedge i_clk);
    o_sfr_wr <= 1'b0;
    // Released data drifts so a stale byte cannot pass
    o_sfr_wdata <= ~d;
    #1;
  endtask

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_sfr_rd <= 1'b1;
    o_sfr_addr <= a;
    @(posedge i_clk);
    o_sfr_rd <= 1'b0;
    #1;
    d = i_sfr_rdata;
  endtask

  task automatic xwrite(input logic [15:0] a, input logic [7:0] d, output int n);
    @(posedge i_clk);
    o_xwr <= 1'b1;
    o_xwr_req <= {a, d};
    @(posedge i_clk);
    o_xwr <= 1'b0;
    o_xwr_req <= ~{a, d};
    #1;
    n = 0;
    while (i_core_stall === 1'b1 && n < 1000) begin
      n++;
      @(posedge i_clk);
      #1;
    end
  endtask

  task automatic xread(input logic [15:0] a);
    @(posedge i_clk);
    o_xrd <= 1'b1;
    o_xrd_addr <= a;
    @(posedge i_clk);
    o_xrd <= 1'b0;
    o_xrd_addr <= ~a;
    #1;
  endtask

  // key pair per operation, enable dropped after
  task automatic store(input logic [15:0] a, input logic [7:0] d, input logic [7:0] ctrl,
                       input int gap, output logic [7:0] k1, output logic [7:0] k2,
                       output int n);
    sfr_write(SFR_UNLOCK_KEY, KEY_FIRST);
    sfr_read(SFR_UNLOCK_KEY, k1);
    repeat (gap) @(posedge i_clk);
    sfr_write(SFR_UNLOCK_KEY, KEY_SECOND);
    sfr_read(SFR_UNLOCK_KEY, k2);
    sfr_write(SFR_STORE_CTRL, ctrl);
    xwrite(a, d, n);
    sfr_write(SFR_STORE_CTRL, 8'h00);
  endtask
endmodule

// file: sim/test_flash_program_erase_guard.sv
`timescale 1ns/1ps
module test_flash_program_erase_guard;
  import fpg_pkg::*;
  localparam int ERASE_N = 20;
  localparam int LIMIT = 20000;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_code_rd = 1'b0;
  logic [15:0] i_code_addr = 16'h0000;
  logic [15:0] i_pc = 16'h0000;
  logic i_dbg_req = 1'b0;
  fpg_dbg_t i_dbg = '0;
  logic sfr_wr, sfr_rd, xwr, xrd, dbg_ack, dbg_denied, ram_wr, ram_rd, stall, err_rst;
  logic sense_full, den;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, code_data, dbg_rdata, k1, k2, d, m;
  fpg_xwr_t xwr_req, ram_wreq;
  logic [15:0] xrd_addr, ram_raddr, a, b;
  int fails = 0;
  int checks = 0;
  int errs = 0;
  int cyc = 0;
  int n, e;

  fpg_guard #(.ERASE_CYCLES(ERASE_N)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_sfr_wr(sfr_wr),
    .i_sfr_rd(sfr_rd), .i_sfr_addr(sfr_addr), .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata),
    .i_xwr(xwr), .i_xwr_req(xwr_req), .i_xrd(xrd), .i_xrd_addr(xrd_addr), .i_pc(i_pc),
    .i_code_rd(i_code_rd), .i_code_addr(i_code_addr), .o_code_data(code_data),
    .i_dbg_req(i_dbg_req), .i_dbg(i_dbg), .o_dbg_ack(dbg_ack), .o_dbg_denied(dbg_denied),
    .o_dbg_rdata(dbg_rdata), .o_data_ram_wr(ram_wr), .o_data_ram_wreq(ram_wreq),
    .o_data_ram_rd(ram_rd), .o_data_ram_raddr(ram_raddr), .o_core_stall(stall),
    .o_flash_err_rst(err_rst), .o_sense_full_cycle(sense_full));

  fpg_core_model core (.i_clk(i_clk), .i_sfr_rdata(sfr_rdata), .i_core_stall(stall),
    .o_sfr_wr(sfr_wr), .o_sfr_rd(sfr_rd), .o_sfr_addr(sfr_addr), .o_sfr_wdata(sfr_wdata),
    .o_xwr(xwr), .o_xwr_req(xwr_req), .o_xrd(xrd), .o_xrd_addr(xrd_addr));

  always #50 i_clk = ~i_clk;

  // Pulses are counted here so checks need not hit the exact cycle
  always @(posedge i_clk) begin
    cyc++;
    if (err_rst === 1'b1) errs++;
    if (cyc == LIMIT) begin
      fails++;
      test_done();
    end
  end

  function automatic logic [7:0] prog(input logic [7:0] old, input logic [7:0] nw);
    return old & nw;
  endfunction

  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask

  task automatic dbg_op(input fpg_dbg_cmd_t c, input logic [13:0] ad, input logic [7:0] dt);
    @(posedge i_clk);
    i_dbg_req <= 1'b1;
    i_dbg <= {c, ad, dt};
    @(posedge i_clk);
    i_dbg_req <= 1'b0;
    #1;
    check("dbg_ack", dbg_ack, 1'b1);
    den = dbg_denied;
    d = dbg_rdata;
  endtask

  task automatic cread(input logic [15:0] pc, input logic [15:0] ad);
    @(posedge i_clk);
    i_pc <= pc;
    i_code_rd <= 1'b1;
    i_code_addr <= ad;
    @(posedge i_clk);
    i_code_rd <= 1'b0;
    #1;
    d = code_data;
  endtask

  initial begin
    void'($urandom(49162));
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    core.sfr_read(SFR_STORE_CTRL, d);
    check("store_ctrl_reset", d, STORE_CTRL_RESET);
    core.sfr_read(SFR_FLASH_SCALE, d);
    check("scale_reset", {sense_full, d}, {1'b0, FLASH_SCALE_RESET});
    core.sfr_read(SFR_UNLOCK_KEY, d);
    check("key_reset", d, 8'h00);
    dbg_op(FPG_DBG_DEVICE_ERASE, 14'h0000, 8'h00);
    core.sfr_write(SFR_FLASH_SCALE, 8'h00);
    core.sfr_read(SFR_FLASH_SCALE, d);
    check("sense_full", {sense_full, d}, 9'h100);
    core.sfr_write(SFR_FLASH_SCALE, 8'hff);
    core.sfr_read(SFR_FLASH_SCALE, d);
    check("scale_bits", {sense_full, d}, 9'h080);
    core.sfr_write(SFR_STORE_CTRL, 8'hfe);
    core.sfr_read(SFR_STORE_CTRL, d);
    check("store_ctrl_bits", d, 8'h02);
    core.sfr_write(SFR_STORE_CTRL, 8'h00);
    a = 16'h0400 + 16'($urandom_range(0, 16'h37ff));
    b = a ^ 16'h0200;
    m = 8'hff;
    for (int i = 0; i < 3; i++) begin
      k1 = 8'($urandom());
      m = prog(m, k1);
      core.store(a, k1, 8'h01, i * 7, k1, k2, n);
      check("key_first", k1, 8'h01);
      check("key_open", k2, 8'h02);
      check("prog_cycles", 24'(n), 24'(PROG_CYCLES));
      cread(16'h0000, a);
      check("prog_data", d, m);
      core.sfr_read(SFR_UNLOCK_KEY, d);
      check("key_relock", d, 8'h00);
    end
    core.store(b, 8'h00, 8'h01, 0, k1, k2, n);
    core.store({a[15:9], 9'($urandom())}, 8'h00, 8'h03, 0, k1, k2, n);
    check("erase_cycles", 24'(n), 24'(ERASE_N));
    cread(16'h0000, a);
    check("erase_data", d, ERASED_BYTE);
    cread(16'h0000, b);
    check("other_page", d, 8'h00);
    core.sfr_write(SFR_STORE_CTRL, 8'h01);
    core.xread(a);
    check("ram_rd", {ram_rd, ram_raddr}, {1'b1, a});
    core.xwrite(a, 8'h5a, n);
    check("op_without_key", 24'(n), 24'h0);
    core.sfr_read(SFR_UNLOCK_KEY, d);
    check("key_dead", d, 8'h03);
    core.sfr_write(SFR_STORE_CTRL, 8'h00);
    core.xwrite(a, 8'h3c, n);
    check("ram_wr", {ram_wr, ram_wreq}, {1'b1, a, 8'h3c});
    core.store(a, 8'h00, 8'h01, 2, k1, k2, n);
    check("dead_key", {k2, 24'(n)}, {8'h03, 24'h000000});
    do_reset();
    core.sfr_write(SFR_UNLOCK_KEY, 8'h5a);
    core.sfr_read(SFR_UNLOCK_KEY, d);
    check("wrong_key", d, 8'h03);
    do_reset();
    dbg_op(FPG_DBG_WRITE, LOCK_BYTE_ADDR, 8'hfe);
    dbg_op(FPG_DBG_READ, 14'h0010, 8'h00);
    check("dbg_lock_p0", {den, d}, 9'h100);
    dbg_op(FPG_DBG_READ, 14'h0210, 8'h00);
    check("dbg_open_p1", {den, d}, 9'h0ff);
    dbg_op(FPG_DBG_READ, 14'h3dfe, 8'h00);
    check("dbg_lock_page", den, 1'b1);
    dbg_op(FPG_DBG_ERASE, 14'h0000, 8'h00);
    check("dbg_erase_denied", den, 1'b1);
    e = errs;
    cread(16'h0400, 16'h0010);
    check("fw_denied", d, 8'h00);
    core.store(16'h0010, 8'h00, 8'h01, 0, k1, k2, n);
    check("fw_write_denied", 24'(n), 24'h0);
    cread(16'h0000, 16'h0010);
    check("fw_locked_read", d, 8'hff);
    cread(16'h0000, 16'h3e00);
    repeat (3) @(posedge i_clk);
    check("err_resets", 24'(errs - e), 24'h3);
    // Protected code cannot erase the lock page; one error reset
    do_reset();
    e = errs;
    core.store({2'b00, LOCK_BYTE_ADDR}, 8'h00, 8'h03, 0, k1, k2, n);
    repeat (3) @(posedge i_clk);
    check("lock_page_erase", {24'(n), 24'(errs - e)}, 24'h1);
    do_reset();
    dbg_op(FPG_DBG_DEVICE_ERASE, 14'h0000, 8'h00);
    dbg_op(FPG_DBG_READ, 14'h0010, 8'h00);
    check("unlocked_after_erase", {den, d}, 9'h0ff);
    dbg_op(FPG_DBG_WRITE, 14'h0210, 8'h5a);
    dbg_op(FPG_DBG_READ, 14'h0210, 8'h00);
    check("dbg_prog", {den, d}, 9'h05a);
    dbg_op(FPG_DBG_ERASE, 14'h03c4, 8'h00);
    dbg_op(FPG_DBG_READ, 14'h0210, 8'h00);
    check("dbg_page_erase", {den, d}, 9'h0ff);
    test_done();
  end
endmodule
